// ---- src/temp_result_defines.svh ----
// Offsets, reset values and timing counts for the temperature result block
`ifndef TEMP_RESULT_DEFINES_SVH
`define TEMP_RESULT_DEFINES_SVH

`define CLOCK_HZ 20000000
`define STARTUP_TIME_US 1500
`define STARTUP_CYCLES ((`STARTUP_TIME_US * (`CLOCK_HZ / 1000000)))
`define SAMPLE_BITS 11
`define AVERAGE_COUNT 32
`define AVERAGE_SHIFT 5
`define RESULT_RESET 11'h400
`define FRAC_LOCAL_LSB 5
`define FRAC_REMOTE_LSB 2

`endif

// ---- src/temp_result_pkg.sv ----
// Types shared by the temperature result block
`default_nettype none
package temp_result_pkg;
    typedef enum logic [1:0] {StStartup, StIdle, StRun} run_state_t;
    typedef enum logic [1:0] {RdFraction, RdLocalUpper, RdRemoteUpper} read_sel_t;
endpackage
`default_nettype wire

// ---- src/sample_if.sv ----
// Carries one channel's raw sample handshake to the averager
`default_nettype none
interface sample_if;
    logic valid;
    logic [10:0] data;
    logic resultValid;
    logic [10:0] result;
    modport source (output valid, output data, input resultValid, input result);
    modport filter (input valid, input data, output resultValid, output result);
endinterface
`default_nettype wire

// ---- src/sample_averager.sv ----
// Averages a fixed number of signed samples for one channel
`include "temp_result_defines.svh"
`default_nettype none
module sample_averager #(
    parameter int COUNT = `AVERAGE_COUNT,
    parameter int SHIFT = `AVERAGE_SHIFT
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clear,
    sample_if.filter port
);
    logic signed [16:0] sum;
    logic [5:0] taken;
    logic signed [16:0] total;

    assign total = sum + 17'(signed'(port.data));

    // ------------------------------------------------------------
    // Accumulation
    // ------------------------------------------------------------
    // Average of 32 samples
    always_ff @(posedge clock)
    begin
        if (rst || clear)
        begin
            sum <= '0;
            taken <= '0;
            port.resultValid <= 1'b0;
            port.result <= `RESULT_RESET;
        end
        else
        begin
            port.resultValid <= 1'b0;
            if (port.valid)
            begin
                if (taken == 6'(COUNT - 1))
                begin
                    port.result <= 11'(total >>> SHIFT);
                    port.resultValid <= 1'b1;
                    sum <= '0;
                    taken <= '0;
                end
                else
                begin
                    sum <= total;
                    taken <= taken + 6'h01;
                end
            end
        end
    end

    avg_count_a: assert property (@(posedge clock) disable iff (rst)
        port.resultValid |-> $past(taken) == 6'(COUNT - 1) && $past(port.valid))
        else $error("average ended with wrong sample count");
endmodule
`default_nettype wire

// ---- src/temperature_conversion_result.sv ----
// Temperature result storage, averaging and freeze logic
`include "temp_result_defines.svh"
`default_nettype none
module temperature_conversion_result #(
    parameter int STARTUP_CYCLES = `STARTUP_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic softReset,
    input wire logic runEnable,
    input wire logic localValid,
    input wire logic [10:0] localSample,
    input wire logic remoteValid,
    input wire logic [10:0] remoteSample,
    input wire logic readStrobe,
    input wire logic [1:0] readSelect,
    output logic [7:0] readData,
    output logic readDataValid,
    output logic busReady,
    output logic converting,
    output logic [7:0] local_temperature_upper_byte,
    output logic [7:0] remote_temperature_upper_byte,
    output logic [7:0] temperature_fraction_byte
);
    temp_result_pkg::run_state_t state;
    logic [20:0] startupCount;
    logic frozen;
    logic [10:0] localResult;
    logic [10:0] remoteResult;
    logic [10:0] pendLocal;
    logic [10:0] pendRemote;
    logic pendLocalValid;
    logic pendRemoteValid;
    logic running;
    logic busOpen;
    logic readFrac;
    logic readRemote;

    sample_if localIf ();
    sample_if remoteIf ();

    function automatic logic [7:0] fraction_byte(input logic [10:0] loc, input logic [10:0] rem);
        fraction_byte = 8'h00;
        fraction_byte[`FRAC_LOCAL_LSB +: 3] = loc[2:0];
        fraction_byte[`FRAC_REMOTE_LSB +: 3] = rem[2:0];
    endfunction

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    assign running = state == temp_result_pkg::StRun;
    assign busOpen = state != temp_result_pkg::StStartup;
    assign readFrac = busOpen && readStrobe && readSelect == 2'(temp_result_pkg::RdFraction);
    assign readRemote = busOpen && readStrobe && readSelect == 2'(temp_result_pkg::RdRemoteUpper);

    assign localIf.valid = running && localValid;
    assign localIf.data = localSample;
    assign remoteIf.valid = running && remoteValid;
    assign remoteIf.data = remoteSample;

    always_ff @(posedge clock)
    begin
        if (rst || softReset)
        begin
            state <= temp_result_pkg::StStartup;
            startupCount <= '0;
        end
        else
        begin
            case (state)
                temp_result_pkg::StStartup:
                begin
                    if (startupCount == 21'(STARTUP_CYCLES - 1))
                        state <= temp_result_pkg::StIdle;
                    else
                        startupCount <= startupCount + 21'h000001;
                end
                temp_result_pkg::StIdle:
                    if (runEnable)
                        state <= temp_result_pkg::StRun;
                default:
                    if (!runEnable)
                        state <= temp_result_pkg::StIdle;
            endcase
        end
    end

    sample_averager localAvg (
        .clock(clock),
        .rst(rst),
        .clear(softReset),
        .port(localIf)
    );
    sample_averager remoteAvg (
        .clock(clock),
        .rst(rst),
        .clear(softReset),
        .port(remoteIf)
    );

    // ------------------------------------------------------------
    // Result storage and read freeze
    // ------------------------------------------------------------
    // Freeze window
    always_ff @(posedge clock)
    begin
        if (rst || softReset)
            frozen <= 1'b0;
        else if (readFrac)
            frozen <= 1'b1;
        else if (readRemote)
            frozen <= 1'b0;
    end

    // Overwrite with newest average, held while frozen
    always_ff @(posedge clock)
    begin
        if (rst || softReset)
        begin
            localResult <= `RESULT_RESET;
            remoteResult <= `RESULT_RESET;
            pendLocal <= `RESULT_RESET;
            pendRemote <= `RESULT_RESET;
            pendLocalValid <= 1'b0;
            pendRemoteValid <= 1'b0;
        end
        else
        begin
            if (localIf.resultValid)
            begin
                pendLocal <= localIf.result;
                pendLocalValid <= 1'b1;
            end
            else if (!frozen && pendLocalValid)
            begin
                localResult <= pendLocal;
                pendLocalValid <= 1'b0;
            end
            if (remoteIf.resultValid)
            begin
                pendRemote <= remoteIf.result;
                pendRemoteValid <= 1'b1;
            end
            else if (!frozen && pendRemoteValid)
            begin
                remoteResult <= pendRemote;
                pendRemoteValid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            local_temperature_upper_byte <= 8'h80;
            remote_temperature_upper_byte <= 8'h80;
            temperature_fraction_byte <= 8'h00;
            busReady <= 1'b0;
            converting <= 1'b0;
        end
        else
        begin
            local_temperature_upper_byte <= localResult[10:3];
            remote_temperature_upper_byte <= remoteResult[10:3];
            temperature_fraction_byte <= fraction_byte(localResult, remoteResult);
            busReady <= busOpen && !softReset;
            converting <= running;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            readData <= 8'h00;
            readDataValid <= 1'b0;
        end
        else
        begin
            readDataValid <= busOpen && readStrobe && readSelect != 2'h3;
            if (readSelect == 2'(temp_result_pkg::RdLocalUpper))
                readData <= localResult[10:3];
            else if (readSelect == 2'(temp_result_pkg::RdRemoteUpper))
                readData <= remoteResult[10:3];
            else if (readSelect == 2'(temp_result_pkg::RdFraction))
                readData <= fraction_byte(localResult, remoteResult);
            else
                readData <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    freeze_hold_a: assert property (@(posedge clock) disable iff (rst || softReset)
        frozen && !$past(softReset) |=> $stable(localResult) && $stable(remoteResult))
        else $error("result changed while frozen");
    halt_hold_a: assert property (@(posedge clock) disable iff (rst || softReset)
        !running && !localIf.resultValid |=> !localIf.resultValid)
        else $error("averager produced while halted");
    bus_ignore_a: assert property (@(posedge clock) disable iff (rst)
        state == temp_result_pkg::StStartup |=> !readDataValid)
        else $error("read answered during startup");
    upper_split_a: assert property (@(posedge clock) disable iff (rst || softReset)
        1'b1 |=> local_temperature_upper_byte == $past(localResult[10:3]))
        else $error("upper byte mismatch");
    reset_code_a: assert property (@(posedge clock)
        $past(rst) |-> localResult == 11'h400 && remoteResult == 11'h400)
        else $error("result reset code wrong");
    update_newest_a: assert property (@(posedge clock) disable iff (rst || softReset)
        !frozen && pendLocalValid && !localIf.resultValid |=> localResult == $past(pendLocal))
        else $error("newest average not stored");
    run_gate_a: assert property (@(posedge clock) disable iff (rst || softReset)
        !runEnable ##1 !runEnable |-> !running)
        else $error("running with run bit clear");
    frac_split_a: assert property (@(posedge clock) disable iff (rst || softReset)
        1'b1 |=> temperature_fraction_byte[7:5] == $past(localResult[2:0]))
        else $error("fraction byte mismatch");
endmodule
`default_nettype wire

// ---- tb/sensor_model.sv ----
// Stand-in for the local and remote sensing diodes
`default_nettype none
module sensor_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [10:0] localTemp,
    input wire logic [10:0] remoteTemp,
    output logic localValid,
    output logic [10:0] localSample,
    output logic remoteValid,
    output logic [10:0] remoteSample
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] phase;
    // ----------------------------------------
    // Sample stream
    // ----------------------------------------
    // Samples alternate base, base plus two
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            phase <= 3'h0;
            localValid <= 1'b0;
            remoteValid <= 1'b0;
            localSample <= 11'h000;
            remoteSample <= 11'h000;
        end
        else
        begin
            phase <= phase + 3'h1;
            localValid <= (phase[1:0] == 2'h3);
            remoteValid <= (phase[1:0] == 2'h3);
            if (phase[1:0] == 2'h3)
            begin
                localSample <= phase[2] ? localTemp + 11'h002 : localTemp;
                remoteSample <= phase[2] ? remoteTemp + 11'h002 : remoteTemp;
            end
            else
            begin
                localSample <= ~localSample;
                remoteSample <= ~remoteSample;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the temperature result block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STARTUP = 20;
    localparam int LIMIT = 3000;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic softReset = 1'b0;
    logic runEnable = 1'b0;
    logic readStrobe = 1'b0;
    logic [1:0] readSelect = 2'h3;
    logic [10:0] localTemp = 11'h0C8;
    logic [10:0] remoteTemp = 11'h7F6;
    logic localValid;
    logic remoteValid;
    logic [10:0] localSample;
    logic [10:0] remoteSample;
    logic [7:0] readData;
    logic readDataValid;
    logic busReady;
    logic converting;
    logic [7:0] upLocal;
    logic [7:0] upRemote;
    logic [7:0] fraction;
    logic [7:0] rd;
    logic got;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int w;
    sensor_model u_sensor_model (.clock(clock), .rst(rst), .localTemp(localTemp),
        .remoteTemp(remoteTemp), .localValid(localValid), .localSample(localSample),
        .remoteValid(remoteValid), .remoteSample(remoteSample));
    temperature_conversion_result #(.STARTUP_CYCLES(STARTUP)) u_temperature_conversion_result (
        .clock(clock), .rst(rst), .softReset(softReset), .runEnable(runEnable),
        .localValid(localValid), .localSample(localSample), .remoteValid(remoteValid),
        .remoteSample(remoteSample), .readStrobe(readStrobe), .readSelect(readSelect),
        .readData(readData), .readDataValid(readDataValid), .busReady(busReady),
        .converting(converting), .local_temperature_upper_byte(upLocal),
        .remote_temperature_upper_byte(upRemote), .temperature_fraction_byte(fraction));
    initial
    begin
        forever #25 clock = ~clock;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic check_bytes(input logic [7:0] l, input logic [7:0] r, input logic [7:0] f);
        check(upLocal, l);
        check(upRemote, r);
        check(fraction, f);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic read_reg(input logic [1:0] sel);
        @(posedge clock);
        readStrobe <= 1'b1;
        readSelect <= sel;
        @(posedge clock);
        readStrobe <= 1'b0;
        readSelect <= 2'h3;
        got = 1'b0;
        rd = 'x;
        repeat (3)
        begin
            #1;
            if (!got && readDataValid === 1'b1)
            begin
                got = 1'b1;
                rd = readData;
            end
            @(posedge clock);
        end
        #1;
    endtask
    task automatic wait_ready();
        w = 0;
        while (busReady !== 1'b1 && w < STARTUP + 4)
        begin
            ticks(1);
            w++;
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic check_reset();
        ticks(1);
        check_bytes(8'h80, 8'h80, 8'h00);
        check(8'(busReady), 8'h00);
        read_reg(2'h1);
        check(8'(got), 8'h00);
        wait_ready();
        check(8'(busReady), 8'h01);
    endtask
    task automatic check_average();
        @(posedge clock);
        runEnable <= 1'b1;
        ticks(3);
        check(8'(converting), 8'h01);
        w = 3;
        while (upLocal === 8'h80 && w < 200)
        begin
            ticks(1);
            w++;
        end
        check(8'(w >= 120), 8'h01);
        ticks(1);
        check_bytes(8'h19, 8'hFE, 8'h3C);
        read_reg(2'h0);
        check(rd, 8'h3C);
        read_reg(2'h1);
        check(rd, 8'h19);
        read_reg(2'h2);
        check(rd, 8'hFE);
    endtask
    task automatic check_freeze();
        read_reg(2'h0);
        check(rd, 8'h3C);
        @(posedge clock);
        localTemp <= 11'h3E6;
        remoteTemp <= 11'h000;
        ticks(300);
        check_bytes(8'h19, 8'hFE, 8'h3C);
        read_reg(2'h1);
        check(rd, 8'h19);
        read_reg(2'h2);
        check(rd, 8'hFE);
        ticks(4);
        check_bytes(8'h7C, 8'h00, 8'hE4);
    endtask
    task automatic check_halt();
        @(posedge clock);
        runEnable <= 1'b0;
        localTemp <= 11'h100;
        remoteTemp <= 11'h100;
        ticks(4);
        check(8'(converting), 8'h00);
        ticks(300);
        check_bytes(8'h7C, 8'h00, 8'hE4);
    endtask
    task automatic check_soft();
        @(posedge clock);
        softReset <= 1'b1;
        @(posedge clock);
        softReset <= 1'b0;
        ticks(2);
        check_bytes(8'h80, 8'h80, 8'h00);
        check(8'(busReady), 8'h00);
        wait_ready();
        check(8'(busReady), 8'h01);
    endtask
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        check_reset();
        check_average();
        check_freeze();
        check_halt();
        check_soft();
        summarize();
    end
endmodule
`default_nettype wire
